// [logic/mhs_defines.svh]
// Constants for the modem handshake and status line block
`ifndef MHS_DEFINES_SVH
`define MHS_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define MHS_CLK_HZ 40000000
`define MHS_CLK_KHZ 40000
`define MHS_BAUD 9600
`define MHS_CONFIRM_S 20
`define MHS_FLASH_MS 125
`define MHS_ACT_MS 250
`define MHS_RI_LOW_MS 250
`define MHS_RI_PERIOD_MS 1000
`define MHS_STARTUP_MS 1000

// ****************************************
// Register byte offsets
// ****************************************
`define MHS_A_CTRL 8'h00
`define MHS_A_MSG_COUNT 8'h04
`define MHS_A_VBAT 8'h08
`define MHS_A_STATUS 8'h0c
`define MHS_A_TXDATA 8'h10
`define MHS_A_RXDATA 8'h14
`define MHS_A_INT_STAT 8'h18
`define MHS_A_INT_MASK 8'h1c

// ****************************************
// Control fields and reset value
// ****************************************
`define MHS_C_LED_DIS 0
`define MHS_C_IN_RANGE 1
`define MHS_C_SCANNING 2
`define MHS_C_READY 3
`define MHS_C_THROTTLE 4
`define MHS_C_PWR_DOWN 5
`define MHS_C_POWERED 6
`define MHS_CTRL_W 7
`define MHS_CTRL_RST 7'h40

// ****************************************
// Status and interrupt fields
// ****************************************
`define MHS_S_RTS 0
`define MHS_S_DTR 1
`define MHS_S_LOW_BAT 2
`define MHS_S_STARTUP 3
`define MHS_S_LINES 4
`define MHS_S_RX_VALID 8
`define MHS_S_TX_BUSY 9
`define MHS_I_BATTERY 0
`define MHS_I_RX 1
`define MHS_I_TX 2
`define MHS_I_RANGE 3
`define MHS_INT_W 4

// ****************************************
// Battery thresholds in millivolts
// ****************************************
`define MHS_VBAT_W 12
`define MHS_VBAT_LOW_MV 12'd3500
`define MHS_VBAT_OK_MV 12'd3600
`define MHS_VBAT_RST 12'hfff

`endif

// [logic/mhs_pkg.sv]
// Types shared by the modem handshake and status line block
`default_nettype none
package mhs_pkg;
    typedef logic [31:0] mhs_word_t;
    typedef logic [7:0] mhs_addr_t;
    typedef logic [7:0] mhs_byte_t;
    typedef enum {MHS_IDLE, MHS_START, MHS_DATA, MHS_STOP} mhs_uart_state_e;
endpackage
`default_nettype wire

// [logic/mhs_sync.sv]
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module mhs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta <= RST;
            sync_out <= RST;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// [logic/mhs_uart.sv]
// Asynchronous serial character transmitter and receiver
`default_nettype none
module mhs_uart #(
    parameter int BAUD_DIV = 4166
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Transmit side
    input wire logic tx_start,
    input wire mhs_pkg::mhs_byte_t tx_byte,
    output logic tx_busy,
    output logic tx_done,
    output logic ser_out,
    // Receive side, input already synchronised
    input wire logic ser_in,
    output mhs_pkg::mhs_byte_t rx_byte,
    output logic rx_strobe
);
    import mhs_pkg::*;

    mhs_uart_state_e tx_st, rx_st;
    logic [15:0] tx_cnt, rx_cnt;
    logic [2:0] tx_bit, rx_bit;
    mhs_byte_t tx_sh;

    generate
        if (BAUD_DIV < 4 || BAUD_DIV > 65535) begin : g_chk
            $error("BAUD_DIV out of range");
        end
    endgenerate

    assign tx_busy = (tx_st != MHS_IDLE);

    // ********************
    // Transmitter, 8N1, idle high
    // ********************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_st <= MHS_IDLE;
            tx_cnt <= 16'h0000;
            tx_bit <= 3'h0;
            tx_sh <= 8'h00;
            ser_out <= 1'b1;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_st == MHS_IDLE) begin
                ser_out <= 1'b1;
                if (tx_start) begin
                    tx_sh <= tx_byte;
                    tx_st <= MHS_START;
                    tx_cnt <= 16'h0000;
                    ser_out <= 1'b0;
                end
            end else if (tx_cnt != 16'(BAUD_DIV - 1)) begin
                tx_cnt <= tx_cnt + 16'h0001;
            end else begin
                tx_cnt <= 16'h0000;
                case (tx_st)
                    MHS_START: begin
                        tx_st <= MHS_DATA;
                        tx_bit <= 3'h0;
                        ser_out <= tx_sh[0];
                    end
                    MHS_DATA: begin
                        if (tx_bit == 3'h7) begin
                            tx_st <= MHS_STOP;
                            ser_out <= 1'b1;
                        end else begin
                            tx_bit <= tx_bit + 3'h1;
                            ser_out <= tx_sh[tx_bit + 3'h1];
                        end
                    end
                    default: begin
                        tx_st <= MHS_IDLE;
                        tx_done <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ********************
    // Receiver, samples mid bit, LSB first
    // ********************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_st <= MHS_IDLE;
            rx_cnt <= 16'h0000;
            rx_bit <= 3'h0;
            rx_byte <= 8'h00;
            rx_strobe <= 1'b0;
        end else begin
            rx_strobe <= 1'b0;
            if (rx_st == MHS_IDLE) begin
                rx_cnt <= 16'h0000;
                if (!ser_in) begin
                    rx_st <= MHS_START;
                end
            end else if (rx_st == MHS_START && rx_cnt == 16'(BAUD_DIV / 2)) begin
                rx_cnt <= 16'h0000;
                rx_bit <= 3'h0;
                rx_st <= ser_in ? MHS_IDLE : MHS_DATA;
            end else if (rx_st != MHS_START && rx_cnt == 16'(BAUD_DIV - 1)) begin
                rx_cnt <= 16'h0000;
                if (rx_st == MHS_DATA) begin
                    rx_byte <= {ser_in, rx_byte[7:1]};
                    rx_bit <= rx_bit + 3'h1;
                    if (rx_bit == 3'h7) begin
                        rx_st <= MHS_STOP;
                    end
                end else begin
                    rx_st <= MHS_IDLE;
                    rx_strobe <= ser_in;
                end
            end else begin
                rx_cnt <= rx_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// [logic/mhs_top.sv]
// Modem handshake, indicator and on-board LED logic with APB registers
//
// Summary of operation
// - Carrier detect low in range, else high
// - CTS high asks host to pause
// - Ring indicator pulses low while messages wait
// - Message waiting low while complete messages held
// - In-range indicator follows carrier detect exactly
// - Low battery below 3.5V, clears above 3.6V
// - Indicator changes coincide with battery event
// - Battery change confirmed within 20 seconds
// - Power LED steady locked, flashing scanning
// - Software disable turns on-board LEDs off outside start-up and power-down
// - All LEDs flash at start-up always
// - TX and RX LEDs flash at power-down
// - Status lines stay inactive pulled-up inputs
// - Characters are 8 data, no parity, 1 stop
//
// Our own choices: the address map and the APB interface to the registers.
`include "mhs_defines.svh"
`default_nettype none
module mhs_top #(
    parameter int CONFIRM_CYC = `MHS_CONFIRM_S * `MHS_CLK_HZ,
    parameter int FLASH_CYC = `MHS_FLASH_MS * `MHS_CLK_KHZ,
    parameter int ACT_CYC = `MHS_ACT_MS * `MHS_CLK_KHZ,
    parameter int RI_LOW_CYC = `MHS_RI_LOW_MS * `MHS_CLK_KHZ,
    parameter int RI_PERIOD_CYC = `MHS_RI_PERIOD_MS * `MHS_CLK_KHZ,
    parameter int STARTUP_CYC = `MHS_STARTUP_MS * `MHS_CLK_KHZ,
    parameter int BAUD_DIV = `MHS_CLK_HZ / `MHS_BAUD
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire mhs_pkg::mhs_addr_t paddr,
    input wire mhs_pkg::mhs_word_t pwdata,
    output mhs_pkg::mhs_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Serial port to host
    output logic rxd_out,
    input wire logic txd_in,
    input wire logic dtr_n_in,
    output logic dsr_n_out,
    input wire logic rts_in,
    output logic cts_out,
    output logic carrier_detect_n,
    output logic ring_n,
    // External indicator lines, active low
    output logic msg_waiting_indicator_n,
    output logic in_range_indicator_n,
    output logic low_battery_indicator_n,
    // Status lines, two-way
    input wire logic [3:0] status_line_in,
    output logic [3:0] status_line_out,
    output logic [3:0] status_line_oe,
    // On-board LEDs, high is lit
    output logic led_power,
    output logic led_tx,
    output logic led_rx
);
    import mhs_pkg::*;

    // ****************************************
    // Parameter checks
    // ****************************************
    generate
        if (CONFIRM_CYC < 1 || FLASH_CYC < 1 || ACT_CYC < 1 || STARTUP_CYC < 1)
        begin : g_chk_time
            $error("Timing counts must be at least one cycle");
        end
        if (RI_PERIOD_CYC <= RI_LOW_CYC || RI_LOW_CYC < 1) begin : g_chk_ri
            $error("Ring low time must be shorter than its period");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    logic [`MHS_CTRL_W-1:0] ctrl;
    logic [7:0] msg_count;
    logic [`MHS_VBAT_W-1:0] vbat;
    logic [`MHS_INT_W-1:0] int_stat;
    logic [`MHS_INT_W-1:0] int_mask;
    logic [`MHS_INT_W-1:0] int_ev;
    mhs_byte_t rx_data;
    logic rx_valid;
    logic rts_s, dtr_n_s, txd_s;
    logic [3:0] lines_s;
    logic acc, wr, rd;
    logic low_bat;
    logic next_low_bat;
    logic [31:0] confirm_cnt;
    logic [31:0] flash_cnt;
    logic flash_on;
    logic [31:0] ri_cnt;
    logic [31:0] startup_cnt;
    logic [31:0] tx_act, rx_act;
    logic tx_start, tx_busy, tx_done;
    mhs_byte_t rx_byte;
    logic rx_strobe;
    logic range_q;
    mhs_word_t next_rdata;
    logic next_err;

    function automatic logic is_hit(input mhs_addr_t a, input mhs_addr_t r);
        return a == r;
    endfunction

    function automatic logic [31:0] dec_cnt(input logic [31:0] c);
        return (c == 32'h00000000) ? c : c - 32'h00000001;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    mhs_sync #(.W(7), .RST(7'h7f)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({status_line_in, txd_in, dtr_n_in, rts_in}),
        .sync_out({lines_s, txd_s, dtr_n_s, rts_s})
    );

    // ****************************************
    // APB decode
    // ****************************************
    assign pready = 1'b1;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;

    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (is_hit(paddr, `MHS_A_CTRL)) begin
            next_rdata[`MHS_CTRL_W-1:0] = ctrl;
        end else if (is_hit(paddr, `MHS_A_MSG_COUNT)) begin
            next_rdata[7:0] = msg_count;
        end else if (is_hit(paddr, `MHS_A_VBAT)) begin
            next_rdata[`MHS_VBAT_W-1:0] = vbat;
        end else if (is_hit(paddr, `MHS_A_STATUS)) begin
            next_rdata[`MHS_S_RTS] = rts_s;
            next_rdata[`MHS_S_DTR] = dtr_n_s;
            next_rdata[`MHS_S_LOW_BAT] = low_bat;
            next_rdata[`MHS_S_STARTUP] = (startup_cnt != 32'h00000000);
            next_rdata[`MHS_S_LINES+3:`MHS_S_LINES] = lines_s;
            next_rdata[`MHS_S_RX_VALID] = rx_valid;
            next_rdata[`MHS_S_TX_BUSY] = tx_busy;
        end else if (is_hit(paddr, `MHS_A_TXDATA)) begin
            next_rdata = 32'h00000000;
        end else if (is_hit(paddr, `MHS_A_RXDATA)) begin
            next_rdata[7:0] = rx_data;
        end else if (is_hit(paddr, `MHS_A_INT_STAT)) begin
            next_rdata[`MHS_INT_W-1:0] = int_stat;
        end else if (is_hit(paddr, `MHS_A_INT_MASK)) begin
            next_rdata[`MHS_INT_W-1:0] = int_mask;
        end else begin
            next_err = 1'b1;
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `MHS_CTRL_RST;
            msg_count <= 8'h00;
            vbat <= `MHS_VBAT_RST;
            int_mask <= 4'h0;
        end else if (wr) begin
            if (is_hit(paddr, `MHS_A_CTRL)) begin
                ctrl <= pwdata[`MHS_CTRL_W-1:0];
            end else if (is_hit(paddr, `MHS_A_MSG_COUNT)) begin
                msg_count <= pwdata[7:0];
            end else if (is_hit(paddr, `MHS_A_VBAT)) begin
                vbat <= pwdata[`MHS_VBAT_W-1:0];
            end else if (is_hit(paddr, `MHS_A_INT_MASK)) begin
                int_mask <= pwdata[`MHS_INT_W-1:0];
            end
        end
    end

    // ****************************************
    // Serial data path
    // ****************************************
    // host throttle
    // Writes while busy or throttled are dropped
    assign tx_start = wr && is_hit(paddr, `MHS_A_TXDATA) && !tx_busy && !rts_s;

    mhs_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tx_start(tx_start),
        .tx_byte(pwdata[7:0]),
        .tx_busy(tx_busy),
        .tx_done(tx_done),
        .ser_out(rxd_out),
        .ser_in(txd_s),
        .rx_byte(rx_byte),
        .rx_strobe(rx_strobe)
    );

    // Received byte holding; a new byte overwrites an unread one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else if (rx_strobe) begin
            rx_data <= rx_byte;
            rx_valid <= 1'b1;
        end else if (rd && is_hit(paddr, `MHS_A_RXDATA)) begin
            rx_valid <= 1'b0;
        end
    end

    // ****************************************
    // Handshake and indicator lines
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            carrier_detect_n <= 1'b1;
            in_range_indicator_n <= 1'b1;
            dsr_n_out <= 1'b1;
            cts_out <= 1'b1;
            msg_waiting_indicator_n <= 1'b1;
            low_battery_indicator_n <= 1'b1;
        end else begin
            carrier_detect_n <= !ctrl[`MHS_C_IN_RANGE];
            in_range_indicator_n <= !ctrl[`MHS_C_IN_RANGE];
            dsr_n_out <= !ctrl[`MHS_C_READY];
            cts_out <= ctrl[`MHS_C_THROTTLE];
            msg_waiting_indicator_n <= (msg_count == 8'h00);
            low_battery_indicator_n <= !next_low_bat;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ri_cnt <= 32'h00000000;
            ring_n <= 1'b1;
        end else if (msg_count == 8'h00) begin
            ri_cnt <= 32'h00000000;
            ring_n <= 1'b1;
        end else begin
            ri_cnt <= (ri_cnt == 32'(RI_PERIOD_CYC - 1)) ? 32'h00000000
                                                        : ri_cnt + 32'h00000001;
            ring_n <= (ri_cnt >= 32'(RI_LOW_CYC));
        end
    end

    assign status_line_out = 4'h0;
    assign status_line_oe = 4'h0;

    // ****************************************
    // Battery monitor
    // ****************************************
    // hysteresis band
    always_comb begin
        next_low_bat = low_bat;
        if (confirm_cnt == 32'(CONFIRM_CYC - 1)) begin
            next_low_bat = !low_bat;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_bat <= 1'b0;
            confirm_cnt <= 32'h00000000;
        end else begin
            low_bat <= next_low_bat;
            if (next_low_bat != low_bat) begin
                confirm_cnt <= 32'h00000000;
            end else if ((!low_bat && vbat < `MHS_VBAT_LOW_MV) ||
                         (low_bat && vbat > `MHS_VBAT_OK_MV)) begin
                confirm_cnt <= confirm_cnt + 32'h00000001;
            end else begin
                confirm_cnt <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            range_q <= 1'b0;
        end else begin
            range_q <= ctrl[`MHS_C_IN_RANGE];
        end
    end

    always_comb begin
        int_ev = 4'h0;
        int_ev[`MHS_I_BATTERY] = (next_low_bat != low_bat);
        int_ev[`MHS_I_RX] = rx_strobe;
        int_ev[`MHS_I_TX] = tx_done;
        int_ev[`MHS_I_RANGE] = (range_q != ctrl[`MHS_C_IN_RANGE]);
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_stat <= 4'h0;
        end else if (wr && is_hit(paddr, `MHS_A_INT_STAT)) begin
            int_stat <= (int_stat & ~pwdata[`MHS_INT_W-1:0]) | int_ev;
        end else begin
            int_stat <= int_stat | int_ev;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_mask);
        end
    end

    // ****************************************
    // On-board LED timing
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flash_cnt <= 32'h00000000;
            flash_on <= 1'b0;
            startup_cnt <= 32'(STARTUP_CYC);
            tx_act <= 32'h00000000;
            rx_act <= 32'h00000000;
        end else begin
            if (flash_cnt == 32'(FLASH_CYC - 1)) begin
                flash_cnt <= 32'h00000000;
                flash_on <= !flash_on;
            end else begin
                flash_cnt <= flash_cnt + 32'h00000001;
            end
            startup_cnt <= dec_cnt(startup_cnt);
            tx_act <= tx_done ? 32'(ACT_CYC) : dec_cnt(tx_act);
            rx_act <= rx_strobe ? 32'(ACT_CYC) : dec_cnt(rx_act);
        end
    end

    // ****************************************
    // On-board LED drive
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            led_power <= 1'b0;
            led_tx <= 1'b0;
            led_rx <= 1'b0;
        end else if (startup_cnt != 32'h00000000) begin
            led_power <= flash_on;
            led_tx <= flash_on;
            led_rx <= flash_on;
        end else if (ctrl[`MHS_C_PWR_DOWN]) begin
            led_power <= 1'b0;
            led_tx <= flash_on;
            led_rx <= flash_on;
        end else if (ctrl[`MHS_C_LED_DIS] || !ctrl[`MHS_C_POWERED]) begin
            led_power <= 1'b0;
            led_tx <= 1'b0;
            led_rx <= 1'b0;
        end else begin
            led_power <= ctrl[`MHS_C_SCANNING] ? flash_on : 1'b1;
            led_tx <= (tx_act != 32'h00000000) && flash_on;
            led_rx <= (rx_act != 32'h00000000) && flash_on;
        end
    end
endmodule
`default_nettype wire

// [tb/mhs_host_model.sv]
// Host side serial partner for the modem block
`default_nettype none
module mhs_host_model #(
    parameter int BAUD_DIV = 8
) (
    // Serial lines
    input wire logic ref_clk,
    input wire logic rxd_out,
    output logic txd_in,
    // Decoded character
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        txd_in = 1'b1;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            txd_in <= f[i];
            repeat (BAUD_DIV) @(posedge ref_clk);
        end
    endtask
    always begin
        @(negedge rxd_out);
        repeat (BAUD_DIV + BAUD_DIV / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            rx_byte[i] <= rxd_out;
            repeat (BAUD_DIV) @(posedge ref_clk);
        end
        rx_stb <= rxd_out;
        @(posedge ref_clk);
        rx_stb <= 1'b0;
    end
endmodule
`default_nettype wire

// [tb/mhs_top_chk.sv]
// Assertion checker for the modem handshake block
`default_nettype none
module mhs_top_chk #(
    parameter int STARTUP_CYC = 20
) (
    // Watched ports
    input wire logic ref_clk, resetn, rxd_out, ring_n, msg_waiting_indicator_n,
    input wire logic carrier_detect_n, in_range_indicator_n, led_power, led_tx, led_rx,
    input wire logic [3:0] status_line_oe
);
    int cnt;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) cnt <= 0;
        else if (cnt < STARTUP_CYC) cnt <= cnt + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_low8; !rxd_out [*8]; endsequence
    sequence s_high8; rxd_out [*8]; endsequence
    property p_follow; in_range_indicator_n == carrier_detect_n; endproperty
    a_follow: assert property (p_follow) else $error("in-range differs");
    property p_oe; status_line_oe == 4'h0; endproperty
    a_oe: assert property (p_oe) else $error("status line driven");
    property p_ring_msg; !ring_n |-> !msg_waiting_indicator_n; endproperty
    a_ring_msg: assert property (p_ring_msg) else $error("ring idle");
    property p_ring_gap; $rose(ring_n) && !msg_waiting_indicator_n |-> ring_n [*5]; endproperty
    a_ring_gap: assert property (p_ring_gap) else $error("ring gap");
    property p_ring_go; $fell(msg_waiting_indicator_n) |-> ##[0:1] !ring_n; endproperty
    a_ring_go: assert property (p_ring_go) else $error("ring start");
    property p_low; $fell(rxd_out) |-> s_low8; endproperty
    a_low: assert property (p_low) else $error("short low bit");
    property p_high; $rose(rxd_out) |-> s_high8; endproperty
    a_high: assert property (p_high) else $error("short high bit");
    property p_start; cnt > 1 && cnt < STARTUP_CYC - 1 |-> led_tx == led_power &&
        led_rx == led_power; endproperty
    a_start: assert property (p_start) else $error("start flash");
endmodule
bind mhs_top mhs_top_chk #(.STARTUP_CYC(STARTUP_CYC)) i_mhs_top_chk (.ref_clk, .resetn,
    .rxd_out, .ring_n, .msg_waiting_indicator_n, .carrier_detect_n, .in_range_indicator_n,
    .led_power, .led_tx, .led_rx, .status_line_oe);
`default_nettype wire

// [tb/mhs_top_tb.sv]
// Self-checking bench for the modem handshake block
`include "mhs_defines.svh"
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module mhs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mhs_pkg::*;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, dtr_n_in = 1, rts_in = 0;
    mhs_addr_t paddr = '0;
    mhs_word_t pwdata = '0, prdata, rq[$];
    logic [3:0] status_line_in = 4'hf, status_line_out, status_line_oe;
    logic pready, pslverr, irq, rxd_out, txd_in, dsr_n_out, cts_out, carrier_detect_n, ring_n;
    logic msg_waiting_indicator_n, in_range_indicator_n, low_battery_indicator_n;
    logic led_power, led_tx, led_rx, rx_stb;
    logic [7:0] rx_byte, b, sq[$];
    int bad_count = 0, tests_run = 0, n;
    logic [11:0] vb[4] = '{12'd3499, 12'd3550, 12'd3601, 12'd3500};
    logic ex[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    mhs_top #(.CONFIRM_CYC(20), .FLASH_CYC(4), .ACT_CYC(10), .RI_LOW_CYC(3),
        .RI_PERIOD_CYC(8), .STARTUP_CYC(20), .BAUD_DIV(8)) i_mhs_top (.ref_clk, .resetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .rxd_out,
        .txd_in, .dtr_n_in, .dsr_n_out, .rts_in, .cts_out, .carrier_detect_n, .ring_n,
        .msg_waiting_indicator_n, .in_range_indicator_n, .low_battery_indicator_n,
        .status_line_in, .status_line_out, .status_line_oe, .led_power, .led_tx, .led_rx);
    mhs_host_model #(.BAUD_DIV(8)) i_mhs_host_model (.ref_clk, .rxd_out, .txd_in, .rx_stb,
        .rx_byte);
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic apb(input mhs_addr_t a, input logic w, input mhs_word_t d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input mhs_addr_t a, input mhs_word_t e);
        rq.push_back(e);
        apb(a, 1'b0, '0);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****
    // Result watchers
    // ****
    always @(posedge ref_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) `CHK("prdata", rq.pop_front(), prdata)
        if (rx_stb === 1'b1) `CHK("serial", sq.pop_front(), rx_byte)
    end
    initial begin
        wt(6000);
        bad_count++;
        close_out;
    end
    initial begin
        void'($urandom(32'hf4b87119));
        wt(8);
        resetn <= 1'b1;
        `CHK("dsr", 1'b1, dsr_n_out)
        rd(`MHS_A_CTRL, 32'h40);
        rd(`MHS_A_VBAT, 32'hfff);
        rd(8'h40, 32'h0);
        `CHK("pslverr", 1'b1, pslverr)
        {status_line_in, dtr_n_in, rts_in} <= 6'($urandom);
        apb(`MHS_A_CTRL, 1'b1, 32'h5a);
        wt(30);
        `CHK("cd", 1'b0, carrier_detect_n)
        `CHK("cts", 1'b1, cts_out)
        `CHK("dsr", 1'b0, dsr_n_out)
        `CHK("pwr", 1'b1, led_power)
        `CHK("ssout", 4'h0, status_line_out)
        rd(`MHS_A_STATUS, 32'({status_line_in, 2'b00, dtr_n_in, rts_in}));
        rts_in <= 1'b0;
        apb(`MHS_A_CTRL, 1'b1, 32'h5b);
        wt(2);
        `CHK("led", 2'b00, {led_power, led_tx})
        apb(`MHS_A_MSG_COUNT, 1'b1, 32'($urandom_range(255, 1)));
        wt(2);
        `CHK("msg", 1'b0, msg_waiting_indicator_n)
        n = 0;
        repeat (8) begin
            @(posedge ref_clk);
            n += !ring_n;
        end
        `CHK("ring", 3, n)
        apb(`MHS_A_MSG_COUNT, 1'b1, 32'h0);
        wt(2);
        `CHK("idle", 2'b11, {ring_n, msg_waiting_indicator_n})
        apb(`MHS_A_INT_MASK, 1'b1, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(`MHS_A_VBAT, 1'b1, 32'(vb[i]));
            wt(30);
            `CHK("lowbat", ex[i], low_battery_indicator_n)
        end
        `CHK("irq", 1'b1, irq)
        apb(`MHS_A_INT_MASK, 1'b1, 32'h0);
        wt(2);
        `CHK("irq", 1'b0, irq)
        apb(`MHS_A_INT_STAT, 1'b1, 32'h1);
        apb(`MHS_A_INT_MASK, 1'b1, 32'h1);
        wt(2);
        `CHK("irq", 1'b0, irq)
        b = 8'($urandom);
        sq.push_back(b);
        apb(`MHS_A_TXDATA, 1'b1, 32'(b));
        wt(100);
        rts_in <= 1'b1;
        wt(3);
        apb(`MHS_A_TXDATA, 1'b1, 32'h55);
        wt(3);
        rd(`MHS_A_STATUS, 32'({status_line_in, 2'b00, dtr_n_in, 1'b1}));
        rts_in <= 1'b0;
        b = 8'($urandom);
        i_mhs_host_model.send(b);
        wt(20);
        rd(`MHS_A_RXDATA, 32'(b));
        wt(4);
        `CHK("queues", 0, rq.size() + sq.size())
        close_out;
    end
endmodule
`default_nettype wire
